/* File: pkg/qdc_cfg.svh */
// Constants for the quad DAC serial command decoder.
// Assumes inclusion by bare name from package and rtl files.
`ifndef QDC_CFG_SVH
`define QDC_CFG_SVH
`define QDC_WORD_BITS   12
`define QDC_DATA_BITS   8
`define QDC_NUM_DACS    4
`define QDC_ADDR_MSB    11
`define QDC_ADDR_LSB    10
`define QDC_CTRL_MSB    9
`define QDC_CTRL_LSB    8
`define QDC_DATA_MSB    7
`define QDC_CLK_NS      10
`define QDC_ZERO_WORD   12'h000
`define QDC_ZERO_BYTE   8'h00
`define QDC_SYNC_IDLE   3'h2
`define QDC_PIPE_HIGH   2'h3
`define QDC_PIPE_LOW    2'h0
`define QDC_C_PRELOAD   2'h1
`define QDC_C_LOADUPD   2'h3
`define QDC_C_SPECIAL   2'h0
`define QDC_C_MISC      2'h2
`define QDC_A_0         2'h0
`define QDC_A_1         2'h1
`define QDC_A_2         2'h2
`define QDC_A_3         2'h3
`endif

/* File: pkg/qdc_pkg.sv */
// Types for the quad DAC serial command decoder.
// Assumes qdc_cfg.svh on the include path.
`include "qdc_cfg.svh"
package qdc_pkg;
  typedef logic [`QDC_DATA_BITS-1:0] qdc_byte_t;
  typedef logic [`QDC_WORD_BITS-1:0] qdc_word_t;
  typedef enum logic [0:0] {
    QDC_PH_FALL = 1'b0,
    QDC_PH_RISE = 1'b1
  } qdc_phase_t;
endpackage : qdc_pkg

/* File: pkg/qdc_link_if.sv */
// Synchronised link events passed from the front end to the decoder.
// Assumes both ends share clock.
`timescale 1ns/1ps
`default_nettype none
interface qdc_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_low;
  logic din;
  modport front (output sclk_rise, output sclk_fall, output cs_rise, output cs_low, output din);
  modport core  (input sclk_rise, input sclk_fall, input cs_rise, input cs_low, input din);
endinterface : qdc_link_if
`default_nettype wire

/* File: rtl/qdc_link_sync.sv */
// Two-flop synchronisers and edge detection for the serial pins.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_cfg.svh"
module qdc_link_sync (
  input  wire logic   clock,
  input  wire logic   arst_n,
  input  wire logic   sclk,
  input  wire logic   chip_select_n,
  input  wire logic   serial_in,
  qdc_link_if.front   link
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_sync;
  logic [2:0] next_prev;

  always_comb begin
    next_meta = {sclk, chip_select_n, serial_in};
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // Idle pin levels (sclk low, deselected), so release gives no false edge
      meta <= `QDC_SYNC_IDLE;
      sync <= `QDC_SYNC_IDLE;
      prev <= `QDC_SYNC_IDLE;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Bit 2 sclk, bit 1 chip select, bit 0 data
  assign link.sclk_rise = sync[2] & ~prev[2];
  assign link.sclk_fall = ~sync[2] & prev[2];
  assign link.cs_rise   = sync[1] & ~prev[1];
  assign link.cs_low    = ~sync[1];
  assign link.din       = sync[0];
endmodule : qdc_link_sync
`default_nettype wire

/* File: rtl/qdc_decoder.sv */
// Serial command decoder of a quad 8-bit DAC: shift register, command
// execution on chip-select rise, input and DAC registers, serial out.
// Assumes serial pins asynchronous to clock, sclk well below clock/4.
// How it works
// R01 - Control 01 loads addressed input register; DAC registers unchanged.
// R02 - Control 11 loads addressed input register, then updates all DACs.
// R03 - Address 01 control 00 copies inputs to DACs, leaves shutdown.
// R04 - Address 10 control 00 writes data to all DACs, leaves shutdown.
// R05 - Address 11 control 00 enters shutdown only when powerdown_allow high.
// R06 - Control 10 with address 00/01 drives user_logic_out low/high.
// R07 - All-zero code changes nothing.
// R08 - Address 11 control 10 selects phase mode 1 and updates DACs.
// R09 - Address 10 control 10 selects phase mode 0 and updates DACs.
// R10 - Phase held until reset (mode 0) or opposite phase command.
// R11 - Word is two address, two control, eight data bits, MSB first.
// R12 - While load_dac_n low DAC registers follow input registers.
// R13 - Host shifts farthest device word first in a chain.
// R14 - Whatever twelve bits sit in the shift register are decoded.
// R15 - With sixteen bits shifted the first four are lost.
// R16 - clear_all_n low clears input and DAC registers synchronously, after a two-flop synchroniser.
// R17 - serial_out lags 11.5 cycles mode 0, 12 mode 1; holds while deselected.
// R18 - Shift only on sclk rises while chip select is low.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_cfg.svh"
module qdc_decoder (
  input  wire logic                                          clock,
  input  wire logic                                          arst_n,
  input  wire logic                                          sclk,
  input  wire logic                                          chip_select_n,
  input  wire logic                                          serial_in,
  input  wire logic                                          load_dac_n,
  input  wire logic                                          clear_all_n,
  input  wire logic                                          powerdown_allow,
  output logic                                               serial_out,
  output logic                                               user_logic_out,
  output logic                                               shutdown,
  output logic                                               phase_rise,
  output logic [`QDC_NUM_DACS*`QDC_DATA_BITS-1:0]            dac_value
);
  qdc_link_if link ();

  qdc_link_sync u_sync (
    .clock         (clock),
    .arst_n        (arst_n),
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .serial_in     (serial_in),
    .link          (link)
  );

  // ==========================================================
  // Pin sync for the level inputs
  logic [1:0] load_dac_n_pipe;
  logic [1:0] clr_pipe;
  logic [1:0] pde_pipe;
  logic [1:0] next_load_dac_n_pipe;
  logic [1:0] next_clr_pipe;
  logic [1:0] next_pde_pipe;
  logic       load_dac_n_low;
  logic       clr_low;

  always_comb begin
    next_load_dac_n_pipe = {load_dac_n_pipe[0], load_dac_n};
    next_clr_pipe  = {clr_pipe[0], clear_all_n};
    next_pde_pipe  = {pde_pipe[0], powerdown_allow};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_dac_n_pipe <= `QDC_PIPE_HIGH;
      clr_pipe  <= `QDC_PIPE_HIGH;
      pde_pipe  <= `QDC_PIPE_LOW;
    end else begin
      load_dac_n_pipe <= next_load_dac_n_pipe;
      clr_pipe  <= next_clr_pipe;
      pde_pipe  <= next_pde_pipe;
    end
  end

  assign load_dac_n_low = ~load_dac_n_pipe[1];
  assign clr_low  = ~clr_pipe[1];

  // ==========================================================
  // Shift register and command decode
  qdc_pkg::qdc_word_t   shreg;
  qdc_pkg::qdc_word_t   next_shreg;
  qdc_pkg::qdc_phase_t  phase;
  qdc_pkg::qdc_phase_t  next_phase;
  qdc_pkg::qdc_byte_t   in_reg  [`QDC_NUM_DACS];
  qdc_pkg::qdc_byte_t   dac_reg [`QDC_NUM_DACS];
  qdc_pkg::qdc_byte_t   next_in_reg  [`QDC_NUM_DACS];
  qdc_pkg::qdc_byte_t   next_dac_reg [`QDC_NUM_DACS];
  logic                 next_upo;
  logic                 next_shdn;
  logic                 next_sout;
  logic [1:0]           cmd_addr;
  logic [1:0]           cmd_ctrl;
  qdc_pkg::qdc_byte_t   cmd_data;
  logic                 do_load_in;
  logic                 do_update;
  logic                 do_bcast;

  assign cmd_addr = shreg[`QDC_ADDR_MSB:`QDC_ADDR_LSB]; // R11
  assign cmd_ctrl = shreg[`QDC_CTRL_MSB:`QDC_CTRL_LSB]; // R11
  assign cmd_data = shreg[`QDC_DATA_MSB:0];             // R11

  always_comb begin
    do_load_in = link.cs_rise & (cmd_ctrl == `QDC_C_PRELOAD ||
                                 cmd_ctrl == `QDC_C_LOADUPD); // R01 R02 R07
    do_update  = link.cs_rise & (cmd_ctrl == `QDC_C_LOADUPD ||
                 (cmd_ctrl == `QDC_C_SPECIAL && cmd_addr == `QDC_A_1) ||
                 (cmd_ctrl == `QDC_C_MISC && cmd_addr[1])); // R02 R03 R08 R09
    do_bcast   = link.cs_rise & cmd_ctrl == `QDC_C_SPECIAL &&
                 cmd_addr == `QDC_A_2; // R04
  end

  always_comb begin
    next_shreg = shreg;
    if (link.cs_low && link.sclk_rise) begin
      // Older bits fall off the top, so a 16-bit frame keeps its last 12
      next_shreg = {shreg[`QDC_WORD_BITS-2:0], link.din}; // R18 R15 R14
    end
    next_phase = phase;
    next_upo   = user_logic_out;
    next_shdn  = shutdown;
    if (link.cs_rise && cmd_ctrl == `QDC_C_MISC) begin
      case (cmd_addr)
        `QDC_A_0: next_upo   = 1'b0;                      // R06
        `QDC_A_1: next_upo   = 1'b1;                      // R06
        `QDC_A_2: next_phase = qdc_pkg::QDC_PH_FALL;      // R09 R10
        `QDC_A_3: next_phase = qdc_pkg::QDC_PH_RISE;      // R08 R10
        default:  next_phase = phase;
      endcase
    end
    if (do_update && cmd_ctrl == `QDC_C_SPECIAL) next_shdn = 1'b0; // R03
    if (do_bcast) next_shdn = 1'b0;                                 // R04
    if (link.cs_rise && cmd_ctrl == `QDC_C_SPECIAL && cmd_addr == `QDC_A_3 &&
        pde_pipe[1]) begin
      next_shdn = 1'b1; // R05
    end
    // Output changes on the selected sclk edge, frozen while deselected
    next_sout = serial_out;
    if (link.cs_low && ((phase == qdc_pkg::QDC_PH_FALL && link.sclk_fall) ||
                        (phase == qdc_pkg::QDC_PH_RISE && link.sclk_rise))) begin
      next_sout = shreg[`QDC_WORD_BITS-1]; // R17
    end
  end

  // ==========================================================
  // Input and DAC registers, one lane per channel
  genvar g;
  generate
    for (g = 0; g < `QDC_NUM_DACS; g = g + 1) begin : g_lane
      always_comb begin
        next_in_reg[g]  = in_reg[g];
        next_dac_reg[g] = dac_reg[g];
        if (do_load_in && cmd_addr == 2'(g)) begin
          next_in_reg[g] = cmd_data; // R01 R02
        end
        if (do_update) begin
          // Addressed lane takes the fresh byte in the same cycle
          next_dac_reg[g] = next_in_reg[g]; // R02 R03 R08 R09
        end
        if (load_dac_n_low) begin
          next_dac_reg[g] = next_in_reg[g]; // R12
        end
        if (do_bcast) begin
          // Broadcast wins over the load line in its own cycle
          next_dac_reg[g] = cmd_data; // R04
        end
        if (clr_low) begin
          // Clear dominates everything, synchronised two cycles late
          next_in_reg[g]  = `QDC_ZERO_BYTE; // R16
          next_dac_reg[g] = `QDC_ZERO_BYTE; // R16
        end
      end

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          in_reg[g]  <= `QDC_ZERO_BYTE;
          dac_reg[g] <= `QDC_ZERO_BYTE;
        end else begin
          in_reg[g]  <= next_in_reg[g];
          dac_reg[g] <= next_dac_reg[g];
        end
      end

      assign dac_value[g*`QDC_DATA_BITS +: `QDC_DATA_BITS] = dac_reg[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shreg          <= `QDC_ZERO_WORD;
      phase          <= qdc_pkg::QDC_PH_FALL;
      user_logic_out <= 1'b0;
      shutdown       <= 1'b0;
      serial_out     <= 1'b0;
    end else begin
      shreg          <= next_shreg;
      phase          <= next_phase;
      user_logic_out <= next_upo;
      shutdown       <= next_shdn;
      serial_out     <= next_sout;
    end
  end

  assign phase_rise = phase;

  // ==========================================================
  // Checks
  sequence cmd_s(logic [1:0] a, logic [1:0] c);
    link.cs_rise && cmd_addr == a && cmd_ctrl == c;
  endsequence

  upo_low_a: assert property (@(posedge clock) disable iff (!arst_n) // R06
    cmd_s(`QDC_A_0, `QDC_C_MISC) |=> !user_logic_out)
    else $error("user output not low");
  upo_high_a: assert property (@(posedge clock) disable iff (!arst_n) // R06
    cmd_s(`QDC_A_1, `QDC_C_MISC) |=> user_logic_out)
    else $error("user output not high");
  phase_rise_a: assert property (@(posedge clock) disable iff (!arst_n) // R08
    cmd_s(`QDC_A_3, `QDC_C_MISC) |=> phase == qdc_pkg::QDC_PH_RISE)
    else $error("phase not rise");
  phase_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R10
    !link.cs_rise |=> $stable(phase))
    else $error("phase changed without command");
  shdn_gate_a: assert property (@(posedge clock) disable iff (!arst_n) // R05
    cmd_s(`QDC_A_3, `QDC_C_SPECIAL) && !pde_pipe[1] |=> shutdown == $past(shutdown))
    else $error("shutdown without allow");
  nop_quiet_a: assert property (@(posedge clock) disable iff (!arst_n) // R07
    cmd_s(`QDC_A_0, `QDC_C_SPECIAL) && !load_dac_n_low && !clr_low |=> $stable(dac_value))
    else $error("nop changed dac");
  bcast_a: assert property (@(posedge clock) disable iff (!arst_n) // R04
    cmd_s(`QDC_A_2, `QDC_C_SPECIAL) && !clr_low
    |=> dac_reg[0] == $past(cmd_data) && dac_reg[3] == $past(cmd_data) && !shutdown)
    else $error("broadcast failed");
  preload_a: assert property (@(posedge clock) disable iff (!arst_n) // R01
    cmd_s(`QDC_A_2, `QDC_C_PRELOAD) && !clr_low && !load_dac_n_low
    |=> in_reg[2] == $past(cmd_data) && $stable(dac_value))
    else $error("preload failed");
  clear_a: assert property (@(posedge clock) disable iff (!arst_n) // R16
    clr_low |=> dac_value == '0)
    else $error("clear failed");
  sout_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R17
    !link.cs_low |=> $stable(serial_out))
    else $error("serial out moved while deselected");
endmodule : qdc_decoder
`default_nettype wire

/* File: tb/qdc_host_model.sv */
// Host serial master model for the quad DAC command decoder.
// Assumes the bench calls xfer and idle_clk; sclk idles low.
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model (
  output logic      sclk,
  output logic      chip_select_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic [35:0] rx;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    rx = '0;
  end
  // Farthest word first, MSB first, n bits of up to 36
  task automatic xfer(input logic [35:0] w, input int n);
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #62.5 sclk = 1'b1;
      #62.5 rx = {rx[34:0], serial_out};
      sclk = 1'b0;
    end
    #62.5 chip_select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_in = ~serial_in;
  endtask : xfer
  // Deliberate clocking while deselected
  task automatic idle_clk(input int n);
    repeat (n) begin
      #62.5 sclk = 1'b1;
      serial_in = ~serial_in;
      #62.5 sclk = 1'b0;
    end
  endtask : idle_clk
endmodule : qdc_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the quad DAC serial command decoder.
// Assumes qdc_host_model drives the serial pins with a 125 ns sclk.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clock, arst_n, load_dac_n, clear_all_n, powerdown_allow;
  logic        sclk, chip_select_n, serial_in, serial_out;
  logic        user_logic_out, shutdown, phase_rise;
  logic [31:0] dac_value;
  int          fails = 0;
  int          total_checks = 0;
  always #5 clock = ~clock;
  qdc_decoder i_qdc_decoder (.clock, .arst_n, .sclk, .chip_select_n, .serial_in,
    .load_dac_n, .clear_all_n, .powerdown_allow, .serial_out, .user_logic_out,
    .shutdown, .phase_rise, .dac_value);
  qdc_host_model u_host (.sclk, .chip_select_n, .serial_in, .serial_out);
  // ======
  // Helpers
  task automatic frame(input logic [35:0] w, input int n);
    u_host.xfer(w, n);
    repeat (8) @(posedge clock);
    #1;
  endtask : frame
  task automatic cmd(input logic [11:0] w);
    frame({24'h0, w}, 12);
  endtask : cmd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // ======
  // Scenarios
  task automatic t_pre;
    `CHK("phase_rst", 1'b0, phase_rise)
    `CHK("upo_rst", 1'b0, user_logic_out)
    for (int i = 0; i < 4; i++) cmd({i[1:0], `QDC_C_PRELOAD, 8'((i + 1) * 17)});
    `CHK("dac_pre", 32'h0, dac_value)
    cmd(12'h4A5);
    `CHK("dac_swld", 32'h44332211, dac_value)
    cmd(12'h166);
    `CHK("dac_keep", 32'h44332211, dac_value)
    cmd(12'hB77);
    `CHK("dac_ldupd", 32'h44772266, dac_value)
    $display("t_pre done");
  endtask : t_pre
  task automatic t_pwr;
    cmd(12'hCFF);
    `CHK("sd_blocked", 1'b0, shutdown)
    @(posedge clock) #1 powerdown_allow = 1'b1;
    cmd(12'hC00);
    `CHK("sd_on", 1'b1, shutdown)
    cmd(12'h400);
    `CHK("sd_off_sw", 1'b0, shutdown)
    `CHK("dac_sw", 32'h44772266, dac_value)
    cmd(12'hC00);
    cmd(12'h85A);
    `CHK("sd_off_bc", 1'b0, shutdown)
    `CHK("dac_bc", 32'h5A5A5A5A, dac_value)
    cmd(12'h400);
    `CHK("dac_inputs", 32'h44772266, dac_value)
    cmd(12'h600);
    `CHK("upo_hi", 1'b1, user_logic_out)
    cmd(12'h2FF);
    `CHK("upo_lo", 1'b0, user_logic_out)
    `CHK("dac_upo", 32'h44772266, dac_value)
    $display("t_pwr done");
  endtask : t_pwr
  task automatic t_nop;
    frame(36'hF5BB, 16);
    `CHK("dac_16b", 32'h44772266, dac_value)
    cmd(12'h0FF);
    `CHK("dac_nop", 32'h44772266, dac_value)
    cmd(12'h400);
    `CHK("dac_16b_ld", 32'h4477BB66, dac_value)
    $display("t_nop done");
  endtask : t_nop
  task automatic t_phase;
    cmd(12'h1CC);
    cmd(12'hE00);
    `CHK("phase_m1", 1'b1, phase_rise)
    `CHK("dac_m1", 32'h4477BBCC, dac_value)
    frame({12'h123, 12'h000, 12'h000}, 36);
    `CHK("dout_m1", 12'h123, u_host.rx[23:12])
    `CHK("dac_chain", 32'h4477BBCC, dac_value)
    cmd(12'h1DD);
    cmd(12'hA00);
    `CHK("phase_m0", 1'b0, phase_rise)
    `CHK("dac_m0", 32'h4477BBDD, dac_value)
    frame({12'h0, 12'h456, 12'hA00}, 24);
    `CHK("dout_m0", 12'h456, u_host.rx[11:0])
    `CHK("phase_kept", 1'b0, phase_rise)
    u_host.idle_clk(6);
    repeat (6) @(posedge clock);
    #1;
    `CHK("dout_hold", 1'b1, serial_out)
    `CHK("dac_idle", 32'h4477BBDD, dac_value)
    $display("t_phase done");
  endtask : t_phase
  task automatic t_hw;
    @(posedge clock) #1 load_dac_n = 1'b0;
    cmd(12'h9EE);
    `CHK("dac_transp", 32'h44EEBBDD, dac_value)
    @(posedge clock) #1 load_dac_n = 1'b1;
    @(posedge clock) #1 clear_all_n = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    `CHK("dac_clr", 32'h0, dac_value)
    clear_all_n = 1'b1;
    cmd(12'h400);
    `CHK("inputs_clr", 32'h0, dac_value)
    $display("t_hw done");
  endtask : t_hw
  // ======
  // Sequence and watchdog
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    // Host keeps the load line high for preload commands
    load_dac_n = 1'b1;
    clear_all_n = 1'b1;
    powerdown_allow = 1'b0;
    repeat (8) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    t_pre();
    t_pwr();
    t_nop();
    t_phase();
    t_hw();
    wrap_up();
  end
  // About 26 frames of 2 us each; generous margin
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
